// [fbg_pkg.sv]
// Constants, register map and carrier types of the fractional baud generator block
package fbg_pkg;

  // ----------------------------------------------------------------
  // Register map (byte offsets on the 3-bit parallel bus)
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_TX_HOLDING = 3'h0;
  localparam logic [2:0] ADDR_DIV_LOW = 3'h1;
  localparam logic [2:0] ADDR_DIV_HIGH = 3'h2;
  localparam logic [2:0] ADDR_DIV_FRAC = 3'h3;
  localparam logic [2:0] ADDR_MODEM_CTRL = 3'h4;
  localparam logic [2:0] ADDR_LINE_STATUS = 3'h5;
  localparam logic [2:0] ADDR_LINE_CTRL = 3'h6;
  localparam logic [2:0] ADDR_SCRATCH = 3'h7;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_DIV_LOW = 8'h01;
  localparam logic [7:0] RST_DIV_HIGH = 8'h00;
  localparam logic [7:0] RST_DIV_FRAC = 8'h00;
  localparam logic [7:0] RST_MODEM_CTRL = 8'h00;
  localparam logic [7:0] RST_LINE_CTRL = 8'h03;
  localparam logic [7:0] RST_SCRATCH = 8'h00;
  localparam logic [16:0] RST_BAUD_COUNT = 17'h00001;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MCR_PRESCALE_BIT = 7;
  localparam int FRAC_VALUE_LSB = 0;
  localparam int FRAC_MODE_LSB = 4;
  localparam int LSR_FIFO_EMPTY_BIT = 5;
  localparam int LSR_TX_EMPTY_BIT = 6;
  localparam int LCR_STOP2_BIT = 2;
  localparam int LCR_PARITY_EN_BIT = 3;
  localparam int LCR_EVEN_PARITY_BIT = 4;
  localparam int LCR_RX_BANK_BIT = 7;

  // ----------------------------------------------------------------
  // Counts and encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] PRESCALE_LAST = 2'h3;
  localparam logic [1:0] MODE_16X = 2'h0;
  localparam logic [1:0] MODE_8X = 2'h1;
  localparam logic [1:0] MODE_4X = 2'h2;
  localparam logic [4:0] SPB_16X = 5'h10;
  localparam logic [4:0] SPB_8X = 5'h08;
  localparam logic [4:0] SPB_4X = 5'h04;
  localparam logic [3:0] MIN_DATA_BITS = 4'h5;
  localparam int TX_FIFO_DEPTH = 64;
  localparam int BUF_ENTRIES = 2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cs_b;
    logic rd_b;
    logic wr_b;
    logic [2:0] addr;
    logic [7:0] wdata;
  } fbg_bus_req_t;

  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
    logic [7:0] frac;
  } fbg_divisor_t;

  typedef enum logic [2:0] {
    TX_IDLE,
    TX_START,
    TX_DATA,
    TX_PARITY,
    TX_STOP
  } fbg_tx_state_t;

  // Sampling clocks per bit time; the unused code falls back to 16X
  function automatic logic [4:0] fbg_samples_per_bit(input logic [1:0] mode);
    case (mode)
      MODE_8X: fbg_samples_per_bit = SPB_8X;
      MODE_4X: fbg_samples_per_bit = SPB_4X;
      default: fbg_samples_per_bit = SPB_16X;
    endcase
  endfunction : fbg_samples_per_bit

endpackage : fbg_pkg

// [fbg_baud_gen.sv]
// One fractional baud generator producing the oversampling tick
`timescale 1ns/1ps
module fbg_baud_gen
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  // Prescaled input clock and divisor
  input wire logic i_presc_tick,
  input fbg_pkg::fbg_divisor_t i_divisor,
  // Sampling clock tick
  output logic o_sample_tick
);
  import fbg_pkg::*;

  typedef struct packed {
    logic [16:0] count;
    logic [3:0] acc;
    logic tick;
  } fbg_gen_state_t;

  fbg_gen_state_t state_ff;
  fbg_gen_state_t nxt_state;
  logic [15:0] int_div;
  logic [4:0] acc_sum;

  // ----------------------------------------------------------------
  // Divide and reload
  // ----------------------------------------------------------------
  // Divisor only sampled at reload, so a write never cuts a period short
  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.tick = 1'b0;
    int_div = {i_divisor.high, i_divisor.low};
    if (int_div == 16'h0000)
    begin
      int_div = 16'h0001;
    end
    acc_sum = {1'b0, state_ff.acc} + {1'b0, i_divisor.frac[FRAC_VALUE_LSB +: 4]};
    if (i_presc_tick)
    begin
      if (state_ff.count <= 17'h00001)
      begin
        // Carry of the phase accumulator stretches this period by one
        nxt_state.tick = 1'b1;
        nxt_state.acc = acc_sum[3:0];
        nxt_state.count = {1'b0, int_div} + {16'h0000, acc_sum[4]};
      end
      else
      begin
        nxt_state.count = state_ff.count - 17'h00001;
      end
    end
  end

  // Odd fractions in 8X or 4X mode spread stretches unevenly over bits, hence bit-time jitter
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
    begin
      state_ff <= '0;
      state_ff.count <= RST_BAUD_COUNT;
    end
    else if (i_clk_en)
    begin
      state_ff <= nxt_state;
    end
  end

  assign o_sample_tick = state_ff.tick;

endmodule : fbg_baud_gen

// [fbg_uart_tx_core.sv]
// Baud generators, prescaler, register file and transmit path of the UART
//
// Notes on behaviour
// - Oscillator ticks pass a divide-by-1 or divide-by-4 prescaler set by control bit 7.
// - Each generator divides prescaled clock by 1 up to 65536 minus 1/16.
// - Sampling tick times transmit shifting and receiver sampling.
// - Transmit and receive directions own separate divisor sets.
// - Reset loads divisor one: low byte 01, high byte and fraction 00.
// - Integer divisor is high byte as bits 15:8, low byte as bits 7:0.
// - Fraction register low nibble adds value/16 to the divisor.
// - Fraction bits 5:4 select 16X, 8X or 4X sampling ratio.
// - Odd fraction in 8X mode may jitter bit times by one prescaled clock.
// - Bus reads and writes work without any oscillator ticks.
// - Eight-bit shifter fed through a two-entry buffer by 64-byte FIFO; the holding register writes its tail.
// - Bit time is 16, 8 or 4 sampling periods; shifter moves per bit.
// - Frame is start, data bits, optional parity, then stop bits.
// - Line status bits 5 and 6 report FIFO and shifter emptiness.
// - Data bit 0 goes out right after the start bit.
// - Bit 5 set when FIFO and buffer empty; bit 6 when FIFO, buffer and shifter empty.
`timescale 1ns/1ps
module fbg_uart_tx_core
#(
  parameter int FIFO_DEPTH = fbg_pkg::TX_FIFO_DEPTH,
  parameter int PTR_W = $clog2(fbg_pkg::TX_FIFO_DEPTH)
)
(
  // Clock, reset and enable
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  // Parallel host bus
  input fbg_pkg::fbg_bus_req_t i_bus,
  output logic [7:0] o_rdata,
  // Oscillator input, one pulse per input clock edge
  input wire logic i_osc_tick,
  // Serial side
  output logic o_tx,
  output logic o_rx_sample_tick
);
  import fbg_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic prev_wr;
    logic [7:0] rdata;
    fbg_divisor_t div_tx;
    fbg_divisor_t div_rx;
    logic [7:0] modem_ctrl;
    logic [7:0] line_ctrl;
    logic [7:0] scratch;
    logic [1:0] presc_cnt;
    logic presc_tick;
    logic [FIFO_DEPTH-1:0][7:0] mem;
    logic [PTR_W:0] wr_ptr;
    logic [PTR_W:0] rd_ptr;
    logic [BUF_ENTRIES-1:0][7:0] buf_data;
    logic [1:0] buf_cnt;
    fbg_tx_state_t tx_state;
    logic [3:0] bit_cnt;
    logic [4:0] tick_cnt;
    logic [7:0] shift;
    logic parity;
    logic stop_left;
    logic tx_line;
  } fbg_top_state_t;

  fbg_top_state_t state_ff;
  fbg_top_state_t nxt_state;

  logic tx_tick;
  logic bus_write;
  logic bus_read;
  logic rx_bank;
  logic fifo_empty;
  logic fifo_full;
  logic fifo_pop;
  logic buf_push;
  logic buf_pop;
  logic buf_ready;
  logic [1:0] cnt_after;
  logic [7:0] fifo_head;
  logic [7:0] buf_head;
  logic [3:0] data_bits;
  logic [4:0] spb;
  logic bit_end;
  logic all_empty;
  logic [7:0] status;
  fbg_divisor_t div_sel;

  // Keeps only the configured number of data bits
  function automatic logic [7:0] fbg_mask_data(input logic [7:0] data, input logic [1:0] len);
    case (len)
      2'h0: fbg_mask_data = data & 8'h1F;
      2'h1: fbg_mask_data = data & 8'h3F;
      2'h2: fbg_mask_data = data & 8'h7F;
      default: fbg_mask_data = data;
    endcase
  endfunction : fbg_mask_data

  // ----------------------------------------------------------------
  // Baud generators
  // ----------------------------------------------------------------
  // Two instances so each direction runs at its own rate
  fbg_baud_gen u_tx_gen
  (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_clk_en(i_clk_en),
    .i_presc_tick(state_ff.presc_tick),
    .i_divisor(state_ff.div_tx),
    .o_sample_tick(tx_tick)
  );

  fbg_baud_gen u_rx_gen
  (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_clk_en(i_clk_en),
    .i_presc_tick(state_ff.presc_tick),
    .i_divisor(state_ff.div_rx),
    .o_sample_tick(o_rx_sample_tick)
  );

  // ----------------------------------------------------------------
  // Shared decode
  // ----------------------------------------------------------------
  // Bus handling uses the core clock only, never the oscillator ticks
  always_comb
  begin
    bus_write = !state_ff.prev_wr && !i_bus.cs_b && !i_bus.wr_b;
    bus_read = !i_bus.cs_b && !i_bus.rd_b;
    rx_bank = state_ff.line_ctrl[LCR_RX_BANK_BIT];
    fifo_empty = state_ff.wr_ptr == state_ff.rd_ptr;
    fifo_full = (state_ff.wr_ptr[PTR_W] != state_ff.rd_ptr[PTR_W])
      && (state_ff.wr_ptr[PTR_W-1:0] == state_ff.rd_ptr[PTR_W-1:0]);
    fifo_head = state_ff.mem[state_ff.rd_ptr[PTR_W-1:0]];
    buf_head = state_ff.buf_data[0];
    buf_ready = state_ff.buf_cnt < 2'(BUF_ENTRIES);
    buf_pop = (state_ff.buf_cnt != 2'h0) && (state_ff.tx_state == TX_IDLE);
    fifo_pop = !fifo_empty && buf_ready;
    buf_push = fifo_pop;
    cnt_after = buf_pop ? state_ff.buf_cnt - 2'h1 : state_ff.buf_cnt;
    data_bits = MIN_DATA_BITS + {2'h0, state_ff.line_ctrl[1:0]};
    spb = fbg_samples_per_bit(state_ff.div_tx.frac[FRAC_MODE_LSB +: 2]);
    bit_end = tx_tick && (state_ff.tick_cnt == spb - 5'h01);
    // Buffer entries count as not yet sent, so bit 5 waits for them too
    all_empty = fifo_empty && (state_ff.buf_cnt == 2'h0);
    status = 8'h00;
    status[LSR_FIFO_EMPTY_BIT] = all_empty;
    status[LSR_TX_EMPTY_BIT] = all_empty && (state_ff.tx_state == TX_IDLE);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.prev_wr = !i_bus.cs_b && !i_bus.wr_b;
    nxt_state.presc_tick = 1'b0;
    div_sel = rx_bank ? state_ff.div_rx : state_ff.div_tx;

    // Prescaler on the oscillator ticks
    if (i_osc_tick)
    begin
      if (state_ff.modem_ctrl[MCR_PRESCALE_BIT])
      begin
        nxt_state.presc_cnt = state_ff.presc_cnt + 2'h1;
        nxt_state.presc_tick = state_ff.presc_cnt == PRESCALE_LAST;
      end
      else
      begin
        nxt_state.presc_tick = 1'b1;
      end
    end

    // Register writes; bit 7 of line control picks the receive divisor bank
    if (bus_write)
    begin
      case (i_bus.addr)
        ADDR_TX_HOLDING:
        begin
          // Writes to a full FIFO are dropped
          if (!fifo_full)
          begin
            nxt_state.mem[state_ff.wr_ptr[PTR_W-1:0]] = i_bus.wdata;
            nxt_state.wr_ptr = state_ff.wr_ptr + 1'b1;
          end
        end
        ADDR_DIV_LOW: div_sel.low = i_bus.wdata;
        ADDR_DIV_HIGH: div_sel.high = i_bus.wdata;
        ADDR_DIV_FRAC: div_sel.frac = i_bus.wdata;
        ADDR_MODEM_CTRL: nxt_state.modem_ctrl = i_bus.wdata;
        ADDR_LINE_CTRL: nxt_state.line_ctrl = i_bus.wdata;
        ADDR_SCRATCH: nxt_state.scratch = i_bus.wdata;
        default: nxt_state.scratch = state_ff.scratch;
      endcase
      // Write back into the bank that line control selects
      if (rx_bank)
      begin
        nxt_state.div_rx = div_sel;
      end
      else
      begin
        nxt_state.div_tx = div_sel;
      end
    end

    // Register reads, registered; idle bus and write-only slot read zero
    nxt_state.rdata = 8'h00;
    if (bus_read)
    begin
      case (i_bus.addr)
        ADDR_DIV_LOW: nxt_state.rdata = rx_bank ? state_ff.div_rx.low : state_ff.div_tx.low;
        ADDR_DIV_HIGH: nxt_state.rdata = rx_bank ? state_ff.div_rx.high : state_ff.div_tx.high;
        ADDR_DIV_FRAC: nxt_state.rdata = rx_bank ? state_ff.div_rx.frac : state_ff.div_tx.frac;
        ADDR_MODEM_CTRL: nxt_state.rdata = state_ff.modem_ctrl;
        ADDR_LINE_STATUS: nxt_state.rdata = status;
        ADDR_LINE_CTRL: nxt_state.rdata = state_ff.line_ctrl;
        ADDR_SCRATCH: nxt_state.rdata = state_ff.scratch;
        default: nxt_state.rdata = 8'h00;
      endcase
    end

    // FIFO head into the two-entry buffer; buffer stall holds the FIFO
    if (fifo_pop)
    begin
      nxt_state.rd_ptr = state_ff.rd_ptr + 1'b1;
    end
    if (buf_pop)
    begin
      nxt_state.buf_data[0] = state_ff.buf_data[1];
    end
    if (buf_push)
    begin
      nxt_state.buf_data[cnt_after[0]] = fifo_head;
    end
    nxt_state.buf_cnt = cnt_after + {1'b0, buf_push};

    // Bit-time counter runs on the transmit sampling tick
    if (state_ff.tx_state != TX_IDLE && tx_tick)
    begin
      nxt_state.tick_cnt = bit_end ? 5'h00 : state_ff.tick_cnt + 5'h01;
    end

    // Framing shifter
    case (state_ff.tx_state)
      TX_IDLE:
      begin
        nxt_state.tx_line = 1'b1;
        if (buf_pop)
        begin
          nxt_state.shift = fbg_mask_data(buf_head, state_ff.line_ctrl[1:0]);
          nxt_state.parity = state_ff.line_ctrl[LCR_EVEN_PARITY_BIT]
            ? ^fbg_mask_data(buf_head, state_ff.line_ctrl[1:0])
            : ~^fbg_mask_data(buf_head, state_ff.line_ctrl[1:0]);
          nxt_state.stop_left = state_ff.line_ctrl[LCR_STOP2_BIT];
          nxt_state.tick_cnt = 5'h00;
          nxt_state.bit_cnt = 4'h0;
          nxt_state.tx_line = 1'b0;
          nxt_state.tx_state = TX_START;
        end
      end
      TX_START:
      begin
        if (bit_end)
        begin
          nxt_state.tx_line = state_ff.shift[0];
          nxt_state.tx_state = TX_DATA;
        end
      end
      TX_DATA:
      begin
        if (bit_end)
        begin
          if (state_ff.bit_cnt == data_bits - 4'h1)
          begin
            if (state_ff.line_ctrl[LCR_PARITY_EN_BIT])
            begin
              nxt_state.tx_line = state_ff.parity;
              nxt_state.tx_state = TX_PARITY;
            end
            else
            begin
              nxt_state.tx_line = 1'b1;
              nxt_state.tx_state = TX_STOP;
            end
          end
          else
          begin
            nxt_state.shift = {1'b0, state_ff.shift[7:1]};
            nxt_state.tx_line = state_ff.shift[1];
            nxt_state.bit_cnt = state_ff.bit_cnt + 4'h1;
          end
        end
      end
      TX_PARITY:
      begin
        if (bit_end)
        begin
          nxt_state.tx_line = 1'b1;
          nxt_state.tx_state = TX_STOP;
        end
      end
      TX_STOP:
      begin
        if (bit_end)
        begin
          if (state_ff.stop_left)
          begin
            nxt_state.stop_left = 1'b0;
          end
          else
          begin
            nxt_state.tx_state = TX_IDLE;
          end
        end
      end
      default: nxt_state.tx_state = TX_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Clock enable low freezes everything, bus included
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
    begin
      state_ff <= '0;
      state_ff.prev_wr <= 1'b1;
      state_ff.div_tx.low <= RST_DIV_LOW;
      state_ff.div_tx.high <= RST_DIV_HIGH;
      state_ff.div_tx.frac <= RST_DIV_FRAC;
      state_ff.div_rx.low <= RST_DIV_LOW;
      state_ff.div_rx.high <= RST_DIV_HIGH;
      state_ff.div_rx.frac <= RST_DIV_FRAC;
      state_ff.modem_ctrl <= RST_MODEM_CTRL;
      state_ff.line_ctrl <= RST_LINE_CTRL;
      state_ff.scratch <= RST_SCRATCH;
      state_ff.tx_state <= TX_IDLE;
      state_ff.tx_line <= 1'b1;
    end
    else if (i_clk_en)
    begin
      state_ff <= nxt_state;
    end
  end

  assign o_rdata = state_ff.rdata;
  assign o_tx = state_ff.tx_line;

endmodule : fbg_uart_tx_core

// [fbg_uart_tx_core_checker.sv]
// Port-level assertions for the transmit core and its baud generators
`timescale 1ns/1ps
module fbg_uart_tx_core_checker
#(
  parameter int FIFO_DEPTH = fbg_pkg::TX_FIFO_DEPTH,
  parameter int PTR_W = $clog2(fbg_pkg::TX_FIFO_DEPTH)
)
(
  // Clock, reset and enable
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  // Host bus and oscillator
  input fbg_pkg::fbg_bus_req_t i_bus,
  input wire logic i_osc_tick,
  // Watched outputs
  input wire logic [7:0] o_rdata,
  input wire logic o_tx,
  input wire logic o_rx_sample_tick
);
  import fbg_pkg::*;

  // Read taken at this edge; a cycle with no oscillator pulse
  logic rd_now;
  logic quiet;
  assign rd_now = i_clk_en && !i_bus.cs_b && !i_bus.rd_b;
  assign quiet = i_clk_en && !i_osc_tick;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_reset_outputs_idle: assert property (disable iff (1'b0)
    !i_rst_b |=> o_tx && o_rdata == 8'h00 && !o_rx_sample_tick)
    else $error("outputs not idle after reset");
  a_rdata_returns_zero: assert property (
    !rd_now && i_clk_en |=> o_rdata == 8'h00)
    else $error("read data left standing");
  a_holding_write_only: assert property (
    rd_now && i_bus.addr == ADDR_TX_HOLDING |=> o_rdata == 8'h00)
    else $error("holding register readable");
  a_status_layout: assert property (
    rd_now && i_bus.addr == ADDR_LINE_STATUS |=>
    (o_rdata & 8'h9F) == 8'h00 && (!o_rdata[6] || o_rdata[5]))
    else $error("line status layout wrong");
  a_status_line_idle: assert property (
    rd_now && i_bus.addr == ADDR_LINE_STATUS ##1 o_rdata[6] |-> $past(o_tx))
    else $error("shifter empty while line low");
  a_rx_tick_needs_osc: assert property (
    quiet [*3] |=> !o_rx_sample_tick)
    else $error("sample tick without oscillator");
  a_tx_moves_on_tick: assert property (
    quiet [*5] |=> !$rose(o_tx))
    else $error("line rose without sampling clock");
  a_first_tick_div_one: assert property (
    $rose(i_rst_b) && i_osc_tick && i_clk_en ##1 i_osc_tick && i_clk_en
    |=> o_rx_sample_tick)
    else $error("divisor one tick missing");

  // Main scenarios reached
  c_status_read: cover property (rd_now && i_bus.addr == ADDR_LINE_STATUS);
  c_frame_start: cover property ($fell(o_tx));
  c_rx_tick: cover property (o_rx_sample_tick);
endmodule : fbg_uart_tx_core_checker

bind fbg_uart_tx_core fbg_uart_tx_core_checker #(.FIFO_DEPTH(FIFO_DEPTH), .PTR_W(PTR_W))
  u_checker (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_clk_en(i_clk_en),
  .i_bus(i_bus), .i_osc_tick(i_osc_tick), .o_rdata(o_rdata), .o_tx(o_tx),
  .o_rx_sample_tick(o_rx_sample_tick));

// [fbg_rx_model.sv]
// Behavioural far-end receiver decoding frames on the serial line
`timescale 1ns/1ps
module fbg_rx_model
(
  // Clock and line
  input wire logic i_clk,
  input wire logic i_line,
  // Frame format: bit length in core cycles, line control copy
  input wire logic [15:0] i_bit_cycles,
  input wire logic [7:0] i_lcr,
  // Decoded character
  output logic o_valid,
  output logic [7:0] o_data,
  output logic o_ok
);
  logic [7:0] data;
  logic par;
  logic ok;
  int k;

  initial o_valid = 1'b0;
  initial o_data = 8'h00;
  initial o_ok = 1'b0;

  // Mid-bit sampling after each start edge; no resync inside a frame
  always
  begin
    @(negedge i_line);
    repeat (i_bit_cycles / 2) @(posedge i_clk);
    ok = (i_line === 1'b0);
    data = 8'h00;
    par = 1'b0;
    for (k = 0; k < 5 + i_lcr[1:0]; k++)
    begin
      repeat (i_bit_cycles) @(posedge i_clk);
      data[k] = i_line;
      par = par ^ i_line;
    end
    if (i_lcr[3])
    begin
      repeat (i_bit_cycles) @(posedge i_clk);
      ok = ok && (i_line === (par ^ !i_lcr[4]));
    end
    for (k = 0; k <= i_lcr[2]; k++)
    begin
      repeat (i_bit_cycles) @(posedge i_clk);
      ok = ok && (i_line === 1'b1);
    end
    o_data <= data;
    o_ok <= ok;
    o_valid <= 1'b1;
    @(posedge i_clk);
    o_valid <= 1'b0;
  end
endmodule : fbg_rx_model

// [tb_fbg_uart_tx_core.sv]
// Self-checking bench for the transmit core and its baud generators
`timescale 1ns/1ps
module tb_fbg_uart_tx_core;
  import fbg_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  logic osc_tick = 1'b1;
  fbg_bus_req_t bus = '{1'b1, 1'b1, 1'b1, 3'h0, 8'h00};
  logic [7:0] rdata;
  logic tx;
  logic rx_tick;
  logic [15:0] bit_cyc = 16'h0010;
  logic [7:0] lcr_m = 8'h03;
  logic rx_valid;
  logic [7:0] rx_data;
  logic rx_ok;
  logic [7:0] rxq [$];
  int err_total = 0;
  int cmp_count = 0;
  int cycles = 0;

  // 25 MHz core clock
  always #20 core_clk = ~core_clk;

  fbg_uart_tx_core DUT (.i_core_clk(core_clk), .i_rst_b(rst_b), .i_clk_en(clk_en),
    .i_bus(bus), .o_rdata(rdata), .i_osc_tick(osc_tick), .o_tx(tx),
    .o_rx_sample_tick(rx_tick));
  fbg_rx_model u_far (.i_clk(core_clk), .i_line(tx), .i_bit_cycles(bit_cyc),
    .i_lcr(lcr_m), .o_valid(rx_valid), .o_data(rx_data), .o_ok(rx_ok));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Strobe low for one edge, then high, so the next write is seen as new
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus <= '{1'b0, 1'b1, 1'b0, a, d};
    @(posedge core_clk);
    bus.cs_b <= 1'b1;
    bus.wr_b <= 1'b1;
  endtask : wr

  task automatic rchk(input logic [2:0] a, input logic [7:0] exp, input string what);
    @(posedge core_clk);
    bus <= '{1'b0, 1'b0, 1'b1, a, 8'h00};
    @(posedge core_clk);
    bus.cs_b <= 1'b1;
    bus.rd_b <= 1'b1;
    #1;
    chk(what, {8'h00, exp}, {8'h00, rdata});
  endtask : rchk

  task automatic wait_rx(input int n);
    for (int k = 0; k < 45000 && rxq.size() < n; k++)
      @(posedge core_clk);
  endtask : wait_rx

  // Old period must run out before the new divisor is in force
  task automatic cfg(input logic [7:0] lo, hi, fr, modem_control_reg, lcr, input int bits);
    wr(ADDR_LINE_CTRL, lcr);
    wr(ADDR_DIV_LOW, lo);
    wr(ADDR_DIV_HIGH, hi);
    wr(ADDR_DIV_FRAC, fr);
    wr(ADDR_MODEM_CTRL, modem_control_reg);
    repeat (1100) @(posedge core_clk);
    bit_cyc <= bits[15:0];
    lcr_m <= lcr;
    rxq.delete();
  endtask : cfg

  task automatic frame(input logic [7:0] lo, hi, fr, modem_control_reg, lcr, d, input int bits,
    input logic [7:0] exp);
    int n;
    cfg(lo, hi, fr, modem_control_reg, lcr, bits);
    wr(ADDR_TX_HOLDING, d);
    n = 0;
    if (lcr == 8'h03)
    begin
      @(negedge tx);
      @(posedge tx);
      while (tx === 1'b1 && n < 5000)
      begin
        @(posedge core_clk);
        #1;
        n++;
      end
      chk("first data bit", bits[15:0], n[15:0]);
    end
    wait_rx(1);
    chk("far end data", {8'h00, exp}, {8'h00, rxq[0]});
    repeat (2 * bits) @(posedge core_clk);
  endtask : frame

  // Collect far-end characters; cut a hang short
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (rx_valid === 1'b1)
    begin
      rxq.push_back(rx_data);
      chk("far end framing", 16'h0001, {15'h0000, rx_ok});
    end
    if (cycles == 100000)
    begin
      err_total++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    int n;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge core_clk);
    osc_tick <= 1'b0;
    // Both banks, with the oscillator stopped
    for (int b = 0; b < 2; b++)
    begin
      wr(ADDR_LINE_CTRL, {b[0], 7'h03});
      rchk(ADDR_DIV_LOW, 8'h01, "div low");
      rchk(ADDR_DIV_HIGH, 8'h00, "div high");
      rchk(ADDR_DIV_FRAC, 8'h00, "div frac");
      wr(ADDR_DIV_LOW, {7'h53, b[0]});
      wr(ADDR_DIV_HIGH, {7'h07, b[0]});
      wr(ADDR_DIV_FRAC, {7'h16, b[0]});
    end
    for (int b = 0; b < 2; b++)
    begin
      wr(ADDR_LINE_CTRL, {b[0], 7'h03});
      rchk(ADDR_DIV_LOW, {7'h53, b[0]}, "bank low");
      rchk(ADDR_DIV_HIGH, {7'h07, b[0]}, "bank high");
      rchk(ADDR_DIV_FRAC, {7'h16, b[0]}, "bank frac");
      wr(ADDR_DIV_LOW, b ? 8'h05 : 8'h01);
      wr(ADDR_DIV_HIGH, 8'h00);
      wr(ADDR_DIV_FRAC, 8'h00);
    end
    wr(ADDR_LINE_CTRL, 8'h03);
    wr(ADDR_LINE_STATUS, 8'h00);
    rchk(ADDR_LINE_STATUS, 8'h60, "idle status");
    rchk(ADDR_TX_HOLDING, 8'h00, "holding read");
    // Receive ticks follow their own divisor of five
    @(posedge core_clk);
    osc_tick <= 1'b1;
    repeat (20) @(posedge core_clk);
    n = 0;
    repeat (100)
    begin
      @(posedge core_clk);
      #1;
      n += (rx_tick === 1'b1);
    end
    chk("rx ticks", 16'h0014, n[15:0]);
    frame(8'h02, 8'h00, 8'h00, 8'h00, 8'h03, 8'h55, 32, 8'h55);
    frame(8'h03, 8'h00, 8'h10, 8'h00, 8'h03, 8'h55, 24, 8'h55);
    frame(8'h01, 8'h00, 8'h20, 8'h00, 8'h03, 8'h55, 4, 8'h55);
    frame(8'h02, 8'h00, 8'h28, 8'h00, 8'h03, 8'h55, 10, 8'h55);
    frame(8'h01, 8'h00, 8'h20, 8'h80, 8'h03, 8'h55, 16, 8'h55);
    frame(8'h01, 8'h00, 8'h30, 8'h00, 8'h03, 8'h55, 16, 8'h55);
    frame(8'h02, 8'h00, 8'h20, 8'h00, 8'h1E, 8'hD3, 8, 8'h53);
    frame(8'h02, 8'h00, 8'h20, 8'h00, 8'h0C, 8'hF6, 8, 8'h16);
    frame(8'h02, 8'h00, 8'h20, 8'h00, 8'h09, 8'h2B, 8, 8'h2B);
    frame(8'h00, 8'h01, 8'h20, 8'h00, 8'h03, 8'h55, 1024, 8'h55);
    // Fill the holding path while the line crawls, then drain it
    cfg(8'h10, 8'h00, 8'h20, 8'h00, 8'h03, 64);
    for (int i = 0; i < 70; i++)
      wr(ADDR_TX_HOLDING, i[7:0]);
    rchk(ADDR_LINE_STATUS, 8'h00, "busy status");
    wait_rx(67);
    repeat (1400) @(posedge core_clk);
    chk("far end count", 16'h0043, 16'(rxq.size()));
    for (int i = 0; i < 67; i++)
      chk("fifo order", i[15:0], {8'h00, rxq[i]});
    rchk(ADDR_LINE_STATUS, 8'h60, "drained status");
    give_verdict();
  end
endmodule : tb_fbg_uart_tx_core
